// ==== shared/rrs_cfg.svh ====
// refresh sequencer constants: port decodes, field positions, timing
// assumes inclusion by bare name from the design file
`ifndef RRS_CFG_SVH
`define RRS_CFG_SVH
// interval timer i/o ports
`define RRS_PORT_CNT1 8'h41
`define RRS_PORT_CTRL 8'h43
// refresh configuration byte fields
`define RRS_MODE_HI_BIT 3
`define RRS_MODE_LO_BIT 2
`define RRS_SLOW_BIT 0
`define RRS_CBR_BIT 1
// refresh intervals in ns and the slow/standard ratio
`define RRS_STD_INTERVAL_NS 15625
`define RRS_SLOW_INTERVAL_NS 125000
`define RRS_SLOW_RATIO (`RRS_SLOW_INTERVAL_NS / `RRS_STD_INTERVAL_NS)
// oscillator prescaler feeding the counter
`define RRS_OSC_KHZ 14318
`define RRS_PRESCALE 4'hc
// reset values
`define RRS_CNT_RST 16'h0000
`define RRS_ROW_RST 10'h000
`define RRS_RW_RST 2'h3
`define RRS_MODE_RST 3'h2
`endif

// ==== shared/rrs_pkg.sv ====
// refresh sequencer types
// assumes rrs_cfg.svh lives alongside
package rrs_pkg;
  typedef logic [7:0] rrs_byte_t;
  typedef logic [9:0] rrs_row_t;
  typedef enum logic [1:0] {
    RRS_SYNC = 2'b00,
    RRS_ASYNC = 2'b01,
    RRS_DECPL = 2'b10
  } rrs_mode_e;
  typedef enum logic [2:0] {
    RRS_IDLE = 3'b000,
    RRS_HOLD = 3'b001,
    RRS_ADDR = 3'b010,
    RRS_ISSUE = 3'b011,
    RRS_SYNC_WAIT = 3'b100,
    RRS_DEC_WAIT = 3'b101
  } rrs_state_e;
endpackage

// ==== src/rrs_refresh_sequencer.sv ====
// refresh interval counter, refresh/dma arbitration and refresh sequencer
// assumes all inputs synchronous to mclk; osc_tick pulses once per osc cycle
`timescale 1ns/1ps
`include "rrs_cfg.svh"

module rrs_refresh_sequencer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic osc_tick,
  input wire logic sysclk,
  input wire logic processor_clock,
  input wire rrs_pkg::rrs_byte_t refresh_config_register,
  input wire rrs_pkg::rrs_byte_t io_addr,
  input wire rrs_pkg::rrs_byte_t io_wdata,
  input wire logic io_write_strobe,
  input wire logic io_read_strobe,
  input wire logic dma_request,
  input wire logic hlda,
  input wire logic cpu_t1_or_idle,
  input wire logic isa_refresh_done,
  input wire logic dram_refresh_done,
  input wire logic burst_ready_ack_in_n,
  input wire logic rdy_in_n,
  output logic hold,
  output rrs_pkg::rrs_row_t sys_addr,
  output logic sys_addr_oe_n,
  output rrs_pkg::rrs_row_t dram_row_col_bus,
  output logic ext_address_latch_strobe,
  output logic isa_refresh_req,
  output logic dram_refresh_req,
  output logic dram_cbr_sel,
  output logic isa_stall,
  output logic dram_stall,
  output logic burst_ready_ack_n,
  output logic isa_ready_ack_n,
  output logic dma_grant,
  output logic refresh_timer_output,
  output rrs_pkg::rrs_byte_t io_rdata,
  output logic io_rdata_valid
);
  import rrs_pkg::*;

  function automatic rrs_byte_t sel_byte(input logic [15:0] v, input logic hi);
    sel_byte = hi ? v[15:8] : v[7:0];
  endfunction

  logic [3:0] pre_r;
  logic [15:0] cnt_r, reload_r, lat_r;
  logic [1:0] rw_r;
  logic [2:0] cmode_r;
  logic bcd_r, null_r, load_pend_r, wr_ph_r, rd_ph_r, lat_v_r;
  logic stat_v_r;
  rrs_byte_t lsb_r, stat_r;
  logic out_prev_r;
  logic [2:0] slow_cnt_r;
  logic ref_pend_r, ref_samp_r, dma_samp_r, ref_go_r;
  logic sys_q_r, cpu_q_r;
  rrs_state_e state_r, state_nxt;
  rrs_mode_e mode_r;
  rrs_row_t row_r;
  logic isa_busy_r, dram_busy_r;

  // port decode; reads of the control port do nothing
  wire wr_cnt = io_write_strobe & (io_addr == `RRS_PORT_CNT1);
  wire wr_ctl = io_write_strobe & (io_addr == `RRS_PORT_CTRL);
  wire rd_cnt = io_read_strobe & (io_addr == `RRS_PORT_CNT1);
  wire cw_c1 = io_wdata[7:6] == 2'b01;
  wire cw_latch = wr_ctl & cw_c1 & (io_wdata[5:4] == 2'b00);
  wire cw_prog = wr_ctl & cw_c1 & (io_wdata[5:4] != 2'b00);
  wire rb = wr_ctl & (io_wdata[7:6] == 2'b11) & io_wdata[2];
  wire rb_cnt = rb & ~io_wdata[5];
  wire rb_st = rb & ~io_wdata[4];

  // count write assembly, lsb/msb order follows the rw field
  wire wr_done = wr_cnt & ((rw_r != 2'b11) | wr_ph_r);
  wire [15:0] wr_val = (rw_r == 2'b01) ? {8'h00, io_wdata} :
                       (rw_r == 2'b10) ? {io_wdata, 8'h00} :
                       {io_wdata, lsb_r};

  // prescaled tick; gate is tied on so every tick counts except one in a counter 1 programming control word or last count byte write cycle
  wire cnt_tick = osc_tick & (pre_r == `RRS_PRESCALE - 4'h1);
  wire mode3 = cmode_r[1:0] == 2'b11;
  wire [15:0] cnt_dec = cnt_r - 16'h0001;
  wire [15:0] cnt_nxt = (cnt_r == 16'h0001) ? reload_r : cnt_dec;
  wire out_nxt = mode3 ? (cnt_nxt > {1'b0, reload_r[15:1]}) :
                 (cnt_nxt != 16'h0001);

  // read mux: latched status first, then latched count, then live count
  wire rd_last = (rw_r != 2'b11) | rd_ph_r;
  wire [7:0] rd_byte = stat_v_r ? stat_r :
                       lat_v_r ? sel_byte(lat_r, rd_ph_r & (rw_r == 2'b11) | rw_r == 2'b10) :
                       sel_byte(cnt_r, rd_ph_r & (rw_r == 2'b11) | rw_r == 2'b10);

  // prescaler from the oscillator
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pre_r <= 4'h0;
    end else if (osc_tick) begin
      pre_r <= cnt_tick ? 4'h0 : pre_r + 4'h1;
    end
  end

  // control word, count load and count-down
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rw_r <= `RRS_RW_RST;
      cmode_r <= `RRS_MODE_RST;
      bcd_r <= 1'b0;
      null_r <= 1'b1;
      load_pend_r <= 1'b0;
      reload_r <= `RRS_CNT_RST;
      cnt_r <= `RRS_CNT_RST;
      refresh_timer_output <= 1'b1;
    end else begin
      if (cw_prog) begin
        rw_r <= io_wdata[5:4];
        cmode_r <= io_wdata[3:1];
        bcd_r <= io_wdata[0];
        null_r <= 1'b1;
        load_pend_r <= 1'b0;
        refresh_timer_output <= 1'b1;
      end
      if (wr_done) begin
        reload_r <= wr_val;
        load_pend_r <= 1'b1;
        null_r <= 1'b1;
      end
      if (cnt_tick & ~cw_prog & ~wr_done) begin
        if (load_pend_r) begin
          cnt_r <= reload_r;
          load_pend_r <= 1'b0;
          null_r <= 1'b0;
        end else begin
          cnt_r <= cnt_nxt;
          refresh_timer_output <= out_nxt;
        end
      end
    end
  end

  // write/read byte phases and the latch commands
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_ph_r <= 1'b0;
      rd_ph_r <= 1'b0;
      lsb_r <= 8'h00;
      lat_r <= `RRS_CNT_RST;
      lat_v_r <= 1'b0;
      stat_r <= 8'h00;
      stat_v_r <= 1'b0;
    end else begin
      if (wr_cnt & (rw_r == 2'b11)) begin
        wr_ph_r <= ~wr_ph_r;
        lsb_r <= io_wdata;
      end
      if (rd_cnt) begin
        if (stat_v_r) begin
          stat_v_r <= 1'b0;
        end else begin
          rd_ph_r <= (rw_r == 2'b11) & ~rd_ph_r;
          if (rd_last) begin
            lat_v_r <= 1'b0;
          end
        end
      end
      // a second latch before the first is read keeps the first value
      if ((cw_latch | rb_cnt) & ~lat_v_r) begin
        lat_r <= cnt_r;
        lat_v_r <= 1'b1;
      end
      if (rb_st & ~stat_v_r) begin
        stat_r <= {refresh_timer_output, null_r, rw_r, cmode_r, bcd_r};
        stat_v_r <= 1'b1;
      end
      if (cw_prog) begin
        wr_ph_r <= 1'b0;
        rd_ph_r <= 1'b0;
        lat_v_r <= 1'b0;
      end
    end
  end

  // read data answers one cycle after the strobe; 43h reads as zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      io_rdata <= 8'h00;
      io_rdata_valid <= 1'b0;
    end else begin
      io_rdata <= rd_cnt ? rd_byte : 8'h00;
      io_rdata_valid <= rd_cnt;
    end
  end

  // timer edge, optionally thinned eight-fold for slow refresh
  wire tmr_rise = refresh_timer_output & ~out_prev_r;
  wire slow_en = refresh_config_register[`RRS_SLOW_BIT];
  wire slow_last = slow_cnt_r == 3'(`RRS_SLOW_RATIO - 1);
  wire ref_event = tmr_rise & (~slow_en | slow_last);
  wire take = (state_r == RRS_IDLE) & (state_nxt != RRS_IDLE);
  wire sys_rise = sysclk & ~sys_q_r;
  wire sys_fall = ~sysclk & sys_q_r;
  wire cpu_rise = processor_clock & ~cpu_q_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      out_prev_r <= 1'b1;
      slow_cnt_r <= 3'h0;
    end else begin
      out_prev_r <= refresh_timer_output;
      if (tmr_rise) begin
        slow_cnt_r <= slow_last ? 3'h0 : slow_cnt_r + 3'h1;
      end
    end
  end

  // pending request: a new timer event beats the clear by a take
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ref_pend_r <= 1'b0;
    end else if (ref_event) begin
      ref_pend_r <= 1'b1;
    end else if (take) begin
      ref_pend_r <= 1'b0;
    end
  end

  // refresh sampled on sysclk rise, dma on fall, winner moved to cpu clock
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sys_q_r <= 1'b0;
      cpu_q_r <= 1'b0;
      ref_samp_r <= 1'b0;
      dma_samp_r <= 1'b0;
      ref_go_r <= 1'b0;
      dma_grant <= 1'b0;
    end else begin
      sys_q_r <= sysclk;
      cpu_q_r <= processor_clock;
      if (take) begin
        ref_samp_r <= 1'b0;
      end else if (sys_rise) begin
        ref_samp_r <= ref_pend_r;
      end
      if (sys_fall) begin
        dma_samp_r <= dma_request;
      end
      if (take) begin
        ref_go_r <= 1'b0;
      end else if (cpu_rise) begin
        ref_go_r <= ref_samp_r & ~dma_samp_r;
        dma_grant <= dma_samp_r & (state_r == RRS_IDLE) & ~ref_go_r;
      end
    end
  end

  // refresh sequence
  wire cfg_hi = refresh_config_register[`RRS_MODE_HI_BIT];
  wire cfg_lo = refresh_config_register[`RRS_MODE_LO_BIT];
  wire [1:0] cfg_mode = {cfg_hi, cfg_lo};
  wire busy = isa_busy_r | dram_busy_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RRS_IDLE: begin
        if (ref_go_r & ~busy) begin
          state_nxt = cfg_hi ? RRS_DEC_WAIT : RRS_HOLD;
        end
      end
      RRS_HOLD: begin
        if (hlda) begin
          state_nxt = RRS_ADDR;
        end
      end
      RRS_ADDR: state_nxt = RRS_ISSUE;
      RRS_ISSUE: begin
        state_nxt = (mode_r == RRS_SYNC) ? RRS_SYNC_WAIT : RRS_IDLE;
      end
      RRS_SYNC_WAIT: begin
        if (~busy) begin
          state_nxt = RRS_IDLE;
        end
      end
      RRS_DEC_WAIT: begin
        if (cpu_t1_or_idle) begin
          state_nxt = RRS_ADDR;
        end
      end
      default: state_nxt = RRS_IDLE;
    endcase
  end

  // output decode from the next state so each pin is a flop
  wire n_issue = state_nxt == RRS_ISSUE;
  wire n_bus = (state_nxt == RRS_ADDR) | n_issue | (state_nxt == RRS_SYNC_WAIT);
  wire n_hold = (state_nxt == RRS_HOLD) | n_bus;
  wire not_dec = mode_r != RRS_DECPL;
  wire isa_busy_nxt = n_issue | (isa_busy_r & ~isa_refresh_done);
  wire dram_busy_nxt = n_issue | (dram_busy_r & ~dram_refresh_done);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= RRS_IDLE;
      mode_r <= RRS_SYNC;
      row_r <= `RRS_ROW_RST;
      isa_busy_r <= 1'b0;
      dram_busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (take) begin
        mode_r <= cfg_hi ? RRS_DECPL : rrs_mode_e'(cfg_mode);
      end
      if (state_r == RRS_ISSUE) begin
        row_r <= row_r + 10'h001;
      end
      // each side finishes on its own done pulse
      isa_busy_r <= isa_busy_nxt;
      dram_busy_r <= dram_busy_nxt;
    end
  end

  // bus, strobe and request pins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hold <= 1'b0;
      sys_addr <= `RRS_ROW_RST;
      sys_addr_oe_n <= 1'b1;
      dram_row_col_bus <= `RRS_ROW_RST;
      ext_address_latch_strobe <= 1'b0;
      isa_refresh_req <= 1'b0;
      dram_refresh_req <= 1'b0;
      dram_cbr_sel <= 1'b0;
    end else begin
      // hold spans the whole sync refresh, in async from the hold request through the issue
      hold <= n_hold & ~(state_r == RRS_IDLE & cfg_hi) & (not_dec | take & ~cfg_hi);
      sys_addr <= row_r;
      sys_addr_oe_n <= ~(n_bus & not_dec);
      dram_row_col_bus <= row_r;
      // low during address setup, rising as requests go out
      ext_address_latch_strobe <= n_issue;
      isa_refresh_req <= n_issue;
      dram_refresh_req <= n_issue;
      dram_cbr_sel <= refresh_config_register[`RRS_CBR_BIT];
    end
  end

  // stalls and ready withholding while a refresh is outstanding
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      isa_stall <= 1'b0;
      dram_stall <= 1'b0;
      burst_ready_ack_n <= 1'b1;
      isa_ready_ack_n <= 1'b1;
    end else begin
      isa_stall <= isa_busy_nxt;
      dram_stall <= dram_busy_nxt;
      burst_ready_ack_n <= dram_busy_nxt | burst_ready_ack_in_n;
      isa_ready_ack_n <= isa_busy_nxt | rdy_in_n;
    end
  end
endmodule

// ==== verification/rrs_props.sv ====
// checker: refresh handshake, address, stall and ready relations
// assumes binding into rrs_refresh_sequencer, one mclk domain
`timescale 1ns/1ps
module rrs_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire rrs_pkg::rrs_byte_t refresh_config_register,
  input wire rrs_pkg::rrs_byte_t io_addr,
  input wire logic io_read_strobe,
  input wire logic hlda,
  input wire logic hold,
  input wire rrs_pkg::rrs_row_t sys_addr,
  input wire logic sys_addr_oe_n,
  input wire rrs_pkg::rrs_row_t dram_row_col_bus,
  input wire logic ext_address_latch_strobe,
  input wire logic isa_refresh_req,
  input wire logic dram_refresh_req,
  input wire logic isa_stall,
  input wire logic dram_stall,
  input wire logic burst_ready_ack_n,
  input wire logic isa_ready_ack_n,
  input wire rrs_pkg::rrs_byte_t io_rdata,
  input wire logic io_rdata_valid
);
  import rrs_pkg::*;
  // mode field as seen by the sequencer
  wire logic [1:0] mode = refresh_config_register[3:2];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // bus grant arrives, then an issue in a hold-based mode
  sequence s_grant;
    hold && $rose(hlda);
  endsequence
  sequence s_issue;
    isa_refresh_req && !mode[1];
  endsequence
  AST_PAIR: assert property (isa_refresh_req |->
    dram_refresh_req && ext_address_latch_strobe) else $error("refresh requests split");
  AST_EDGE: assert property (isa_refresh_req |-> !$past(ext_address_latch_strobe))
    else $error("latch strobe without rising edge");
  AST_GRANT: assert property (s_issue |-> hold && $past(hlda) && !sys_addr_oe_n
    && sys_addr == dram_row_col_bus) else $error("issue without grant or address");
  AST_ANSWER: assert property (s_grant |-> ##[1:3] isa_refresh_req)
    else $error("no issue after grant");
  AST_SYNC_END: assert property (mode == 2'b00 && $fell(hold) |->
    !isa_stall && !dram_stall) else $error("hold released early");
  AST_ASYNC_DROP: assert property (isa_refresh_req && mode == 2'b01 |-> ##[1:2] !hold)
    else $error("hold kept after issue");
  AST_DECPL: assert property (isa_refresh_req && mode[1] |-> !hold && sys_addr_oe_n)
    else $error("decoupled used the cpu bus");
  AST_STALL: assert property (isa_refresh_req |=> isa_stall && dram_stall)
    else $error("stall missing after issue");
  AST_BURST_READY_ACK: assert property (dram_stall && $past(dram_stall) |-> burst_ready_ack_n)
    else $error("burst ready during refresh");
  AST_RDY: assert property (isa_stall && $past(isa_stall) |-> isa_ready_ack_n)
    else $error("ready during isa refresh");
  AST_CTRL_RD: assert property (io_read_strobe && io_addr == 8'h43 |=>
    !io_rdata_valid && io_rdata == 8'h00) else $error("control port read not empty");
endmodule

bind rrs_refresh_sequencer rrs_props rrs_props_i (.mclk, .rst_n, .refresh_config_register,
  .io_addr, .io_read_strobe, .hlda, .hold, .sys_addr, .sys_addr_oe_n, .dram_row_col_bus,
  .ext_address_latch_strobe, .isa_refresh_req, .dram_refresh_req, .isa_stall, .dram_stall,
  .burst_ready_ack_n, .isa_ready_ack_n, .io_rdata, .io_rdata_valid);

// ==== verification/rrs_far_side.sv ====
// far side model: cpu bus grant, isa and dram completion, slot latch
// assumes delays stay steady during a refresh
`timescale 1ns/1ps
module rrs_far_side (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] hlda_dly,
  input wire logic [3:0] isa_dly,
  input wire logic [3:0] dram_dly,
  input wire logic hold,
  input wire logic isa_refresh_req,
  input wire logic dram_refresh_req,
  input wire logic ext_address_latch_strobe,
  input wire logic sys_addr_oe_n,
  input wire rrs_pkg::rrs_row_t sys_addr,
  output logic hlda,
  output logic isa_refresh_done,
  output logic dram_refresh_done,
  output rrs_pkg::rrs_row_t slot_addr
);
  import rrs_pkg::*;
  logic [3:0] hcnt_r, icnt_r, dcnt_r;
  rrs_row_t own_row_r;
  // grant after a set wait; completions count down from each request
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hcnt_r <= 4'h0;
      icnt_r <= 4'h0;
      dcnt_r <= 4'h0;
      hlda <= 1'b0;
      isa_refresh_done <= 1'b0;
      dram_refresh_done <= 1'b0;
      own_row_r <= 10'h000;
      slot_addr <= 10'h000;
    end else begin
      hcnt_r <= hold ? hcnt_r + 4'h1 : 4'h0;
      hlda <= hold && hcnt_r >= hlda_dly;
      icnt_r <= isa_refresh_req ? isa_dly : (icnt_r != 4'h0 ? icnt_r - 4'h1 : 4'h0);
      dcnt_r <= dram_refresh_req ? dram_dly : (dcnt_r != 4'h0 ? dcnt_r - 4'h1 : 4'h0);
      isa_refresh_done <= icnt_r == 4'h1;
      dram_refresh_done <= dcnt_r == 4'h1;
      // board latch: own counter when the device leaves the bus alone
      if (ext_address_latch_strobe) begin
        slot_addr <= sys_addr_oe_n ? own_row_r : sys_addr;
        own_row_r <= own_row_r + 10'h001;
      end
    end
  end
endmodule

// ==== verification/rrs_refresh_sequencer_tb_top.sv ====
// testbench: timer ports, three refresh modes, dma arbitration, intervals
// assumes rrs_far_side and the bound checker are compiled alongside
`timescale 1ns/1ps
module rrs_refresh_sequencer_tb_top;
  import rrs_pkg::*;
  logic mclk, rst_n, osc_tick, sysclk, processor_clock, io_write_strobe, io_read_strobe;
  logic dma_request, hlda, cpu_t1_or_idle, isa_refresh_done, dram_refresh_done;
  logic burst_ready_ack_in_n, rdy_in_n, hold, sys_addr_oe_n, ext_address_latch_strobe;
  logic isa_refresh_req, dram_refresh_req, dram_cbr_sel, isa_stall, dram_stall;
  logic burst_ready_ack_n, isa_ready_ack_n, dma_grant, refresh_timer_output, io_rdata_valid;
  rrs_byte_t refresh_config_register, io_addr, io_wdata, io_rdata;
  rrs_row_t sys_addr, dram_row_col_bus, slot_addr, row;
  logic [3:0] hlda_dly, isa_dly, dram_dly;
  logic [2:0] ph;
  int err_total, checked, r, q;
  rrs_refresh_sequencer rrs_refresh_sequencer_i (.mclk, .rst_n, .osc_tick, .sysclk,
    .processor_clock, .refresh_config_register, .io_addr, .io_wdata, .io_write_strobe,
    .io_read_strobe, .dma_request, .hlda, .cpu_t1_or_idle, .isa_refresh_done,
    .dram_refresh_done, .burst_ready_ack_in_n, .rdy_in_n, .hold, .sys_addr, .sys_addr_oe_n,
    .dram_row_col_bus, .ext_address_latch_strobe, .isa_refresh_req, .dram_refresh_req,
    .dram_cbr_sel, .isa_stall, .dram_stall, .burst_ready_ack_n, .isa_ready_ack_n,
    .dma_grant, .refresh_timer_output, .io_rdata, .io_rdata_valid);
  rrs_far_side rrs_far_side_i (.mclk, .rst_n, .hlda_dly, .isa_dly, .dram_dly, .hold,
    .isa_refresh_req, .dram_refresh_req, .ext_address_latch_strobe, .sys_addr_oe_n,
    .sys_addr, .hlda, .isa_refresh_done, .dram_refresh_done, .slot_addr);
  // clock, then slow phases: osc tick every other cycle, sysclk at quarter rate
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    ph <= ph + 3'h1;
    osc_tick <= ph[0];
    sysclk <= ph[1];
    processor_clock <= ph[0];
  end
  task cmp_b(input logic a, input logic e);
    checked++;
    if (a !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, a, e);
    end
  endtask
  task cmp_v(input logic [9:0] a, input logic [9:0] e);
    checked++;
    if (a !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, a, e);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // bounded wait for the paired refresh request pulse
  task wait_req(input int n);
    int i;
    i = 0;
    do begin
      step(1);
      i++;
    end while (isa_refresh_req !== 1'b1 && i < n);
    cmp_b(isa_refresh_req, 1'b1);
  endtask
  task quiet(input int n);
    int k;
    k = 0;
    repeat (n) begin
      step(1);
      k += (isa_refresh_req | hold);
    end
    cmp_v(10'(k), 10'h000);
  endtask
  task io_wr(input rrs_byte_t a, input rrs_byte_t d);
    @(posedge mclk);
    io_addr <= a;
    io_wdata <= d;
    io_write_strobe <= 1'b1;
    @(posedge mclk);
    io_write_strobe <= 1'b0;
  endtask
  task io_rd(input rrs_byte_t a, input rrs_byte_t m, input rrs_byte_t e);
    @(posedge mclk);
    io_addr <= a;
    io_read_strobe <= 1'b1;
    @(posedge mclk);
    io_read_strobe <= 1'b0;
    #1;
    cmp_b(io_rdata_valid, a == 8'h41);
    cmp_v(10'(io_rdata & m), 10'(e));
  endtask
  // mode 2, both bytes, count 4; status read back, control port read empty
  task t_timer;
    io_wr(8'h43, 8'h74);
    io_wr(8'h41, 8'h04);
    io_wr(8'h41, 8'h00);
    io_wr(8'h43, 8'he4);
    io_rd(8'h41, 8'h3f, 8'h34);
    io_rd(8'h43, 8'hff, 8'h00);
    // count 4 is loaded by now and a tick is still ahead, so the latch holds 4
    step(26);
    io_wr(8'h43, 8'h40);
    io_rd(8'h41, 8'hff, 8'h04);
    io_rd(8'h41, 8'hff, 8'h00);
  endtask
  // dma holds the bus, so no refresh may start; mode changes while quiet
  task mode_sw(input rrs_byte_t c);
    @(posedge mclk);
    dma_request <= 1'b1;
    step(40);
    quiet(160);
    cmp_b(dma_grant, 1'b1);
    @(posedge mclk);
    refresh_config_register <= c;
    dma_request <= 1'b0;
    cpu_t1_or_idle <= ~c[3];
  endtask
  task t_sync;
    wait_req(400);
    cmp_b(dram_refresh_req, 1'b1);
    cmp_b(ext_address_latch_strobe, 1'b1);
    cmp_b(sys_addr_oe_n, 1'b0);
    row = dram_row_col_bus;
    step(4);
    cmp_b(hold, 1'b1);
    step(8);
    cmp_b(hold, 1'b0);
    cmp_b(isa_stall, 1'b0);
  endtask
  task t_async;
    wait_req(400);
    cmp_b(dram_cbr_sel, 1'b1);
    cmp_v(dram_row_col_bus, row + 10'h001);
    row = dram_row_col_bus;
    step(2);
    cmp_b(hold, 1'b0);
    cmp_b(isa_ready_ack_n, 1'b1);
    step(4);
    cmp_b(dram_stall, 1'b0);
    cmp_b(isa_stall, 1'b1);
    cmp_b(burst_ready_ack_n, 1'b0);
    cmp_v(slot_addr, row);
    step(8);
  endtask
  task t_dec;
    quiet(100);
    @(posedge mclk);
    cpu_t1_or_idle <= 1'b1;
    wait_req(6);
    cmp_b(sys_addr_oe_n, 1'b1);
    step(2);
    cmp_b(burst_ready_ack_n, 1'b1);
    cmp_b(isa_ready_ack_n, 1'b1);
    step(10);
  endtask
  task rate(input rrs_byte_t c);
    logic p;
    r = 0;
    q = 0;
    p = refresh_timer_output;
    @(posedge mclk);
    refresh_config_register <= c;
    repeat (1536) begin
      step(1);
      r += (refresh_timer_output && !p);
      q += isa_refresh_req;
      p = refresh_timer_output;
    end
  endtask
  task results;
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watchdog well beyond the expected few thousand cycles
  initial begin
    #100000;
    err_total++;
    results;
  end
  initial begin
    {rst_n, io_write_strobe, io_read_strobe, dma_request, ph} = '0;
    {osc_tick, sysclk, processor_clock, burst_ready_ack_in_n, rdy_in_n} = '0;
    {refresh_config_register, io_addr, io_wdata, row} = '0;
    cpu_t1_or_idle = 1'b1;
    {hlda_dly, isa_dly, dram_dly} = {4'h3, 4'h6, 4'h2};
    err_total = 0;
    checked = 0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    t_timer;
    mode_sw(8'h00);
    t_sync;
    {hlda_dly, isa_dly} = {4'h1, 4'h8};
    mode_sw(8'h06);
    t_async;
    mode_sw(8'h08);
    t_dec;
    rate(8'h08);
    cmp_b(r >= 15 && r <= 17, 1'b1);
    cmp_b(q >= r - 1, 1'b1);
    rate(8'h09);
    cmp_b(q >= 1 && q <= r / 8 + 1, 1'b1);
    results;
  end
endmodule
